// ---- test/fspsl_host_model.sv ----
// Behavioural host issuing command writes and reads
module fspsl_host_model #(
  parameter PW = 3
) (
  input wire mclk_in,
  output logic wr_out,
  output logic rd_out,
  output logic [PW-1:0] part_out,
  output logic [15:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    part_out = '0;
    data_out = 16'h0000;
  end
  // Idle data line shows the inverse of the last word
  task automatic write(input logic [PW-1:0] p, input logic [15:0] d);
    @(posedge mclk_in);
    #1;
    wr_out = 1'b1;
    part_out = p;
    data_out = d;
    @(posedge mclk_in);
    #1;
    wr_out = 1'b0;
    data_out = ~d;
  endtask
  // Reads may target any partition during an operation
  task automatic read(input logic [PW-1:0] p);
    @(posedge mclk_in);
    #1;
    rd_out = 1'b1;
    part_out = p;
    @(posedge mclk_in);
    #1;
    rd_out = 1'b0;
  endtask
endmodule // fspsl_host_model

// ---- test/fspsl_status_bench.sv ----
// Self-checking bench for the partition status block
`include "fspsl_regs.vh"
module fspsl_status_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PW = 3;
  logic mclk_in, rst_in, wr_in, rd_in;
  logic [PW-1:0] part_in, op_part_out, p;
  logic [15:0] data_in, array_data_in, data_out, w;
  logic block_locked_in, supply_low_in, op_fail_in, data_valid_out;
  logic state_machine_ready_out, program_busy_out, erase_busy_out;
  logic [15:0] exp_q[$];
  int error_cnt, comparisons, k;
  assign array_data_in = {12'hA50, 1'b0, part_in};
  fspsl_status #(.NP(8), .PW(PW), .PROG_CYCLES(16'h0010),
    .ERASE_CYCLES(16'h0010), .BULK_CYCLES(16'h0008)) i_fspsl_status (
    .mclk_in(mclk_in), .rst_in(rst_in), .wr_in(wr_in), .rd_in(rd_in),
    .part_in(part_in), .data_in(data_in), .array_data_in(array_data_in),
    .block_locked_in(block_locked_in), .supply_low_in(supply_low_in),
    .op_fail_in(op_fail_in), .data_out(data_out),
    .data_valid_out(data_valid_out),
    .state_machine_ready_out(state_machine_ready_out),
    .program_busy_out(program_busy_out), .erase_busy_out(erase_busy_out),
    .op_part_out(op_part_out));
  fspsl_host_model #(.PW(PW)) i_fspsl_host_model (.mclk_in(mclk_in),
    .wr_out(wr_in), .rd_out(rd_in), .part_out(part_in), .data_out(data_in));
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: read %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (exp_q.size() != 0) begin
      error_cnt++;
      $display("Error at %0t: reads left unanswered", $time);
    end
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [PW-1:0] a, input logic [15:0] d);
    i_fspsl_host_model.write(a, d);
  endtask
  task automatic cmd2(input logic [PW-1:0] a, input logic [7:0] c,
                      input logic [15:0] d);
    wr(a, {8'h00, c});
    wr(a, d);
  endtask
  // Note the expected word, then issue the read
  task automatic rd(input logic [PW-1:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    i_fspsl_host_model.read(a);
  endtask
  task automatic rs(input logic [PW-1:0] a, input logic [7:0] s);
    rd(a, {`FSPSL_STATUS_HIGH, s});
  endtask
  task automatic wait_ready();
    int n = 0;
    while (state_machine_ready_out !== 1'b1) begin
      @(posedge mclk_in);
      #1;
      n++;
      if (n > 200) begin
        error_cnt++;
        $display("Error at %0t: device stays busy", $time);
        finish_test();
      end
    end
  endtask
  always @(negedge mclk_in) begin
    if (data_valid_out === 1'b1) begin
      check(data_out, exp_q.pop_front());
    end
  end
  initial begin
    w = 16'($urandom(32'hF63BBB9C));
    rst_in = 1'b1;
    block_locked_in = 1'b0;
    supply_low_in = 1'b0;
    op_fail_in = 1'b0;
    repeat (20) @(posedge mclk_in);
    #1;
    rst_in = 1'b0;
    rd(3'd1, 16'hA501);
    wr(3'd0, {8'h00, `FSPSL_CMD_READ_STATUS});
    rs(3'd0, 8'h80);
    // Program with reads served from other partitions
    wr(3'd2, {8'h00, `FSPSL_CMD_CLEAR_STATUS});
    cmd2(3'd2, `FSPSL_CMD_PROG_SETUP_ALT, w);
    rd(3'd4, 16'hA504);
    wr(3'd3, {8'h00, `FSPSL_CMD_READ_STATUS});
    rs(3'd3, 8'h01);
    rs(3'd2, 8'h00);
    wait_ready();
    rs(3'd2, 8'h80);
    // Failed erase, then blocked operations accumulate errors
    op_fail_in = 1'b1;
    cmd2(3'd1, `FSPSL_CMD_ERASE_SETUP, {8'h00, `FSPSL_CMD_CONFIRM});
    rd(3'd5, 16'hA505);
    wait_ready();
    op_fail_in = 1'b0;
    rs(3'd1, 8'hA0);
    block_locked_in = 1'b1;
    cmd2(3'd1, `FSPSL_CMD_PROG_SETUP, ~w);
    rs(3'd1, 8'hA2);
    block_locked_in = 1'b0;
    supply_low_in = 1'b1;
    cmd2(3'd1, `FSPSL_CMD_ERASE_SETUP, {8'h00, `FSPSL_CMD_CONFIRM});
    rs(3'd1, 8'hAA);
    supply_low_in = 1'b0;
    wr(3'd1, {8'h00, `FSPSL_CMD_CLEAR_STATUS});
    rd(3'd1, 16'hA501);
    wr(3'd1, {8'h00, `FSPSL_CMD_READ_STATUS});
    rs(3'd1, 8'h80);
    // Sequence error on bad erase confirm; lock and program errors on bulk setup of a locked block
    cmd2(3'd2, `FSPSL_CMD_ERASE_SETUP, {8'h00, `FSPSL_CMD_READ_STATUS});
    rs(3'd2, 8'hB0);
    block_locked_in = 1'b1;
    cmd2(3'd4, `FSPSL_CMD_BULK_SETUP, {8'h00, `FSPSL_CMD_CONFIRM});
    rs(3'd4, 8'h92);
    block_locked_in = 1'b0;
    // Overlap refused, then each operation suspended and resumed
    for (k = 0; k < 2; k++) begin
      p = (k == 0) ? 3'd0 : 3'd6;
      if (k == 0) begin
        cmd2(p, `FSPSL_CMD_ERASE_SETUP, {8'h00, `FSPSL_CMD_CONFIRM});
        wr(3'd5, {8'h00, `FSPSL_CMD_PROG_SETUP});
        wr(3'd5, {8'h00, `FSPSL_CMD_READ_STATUS});
        rs(3'd5, 8'h31);
      end else begin
        cmd2(p, `FSPSL_CMD_PROG_SETUP, 16'($urandom()));
      end
      wr(p, {8'h00, `FSPSL_CMD_SUSPEND});
      rs(p, (k == 0) ? 8'hC0 : 8'h84);
      wr(p ^ 3'd3, {8'h00, `FSPSL_CMD_PROG_SETUP});
      rs(p ^ 3'd3, (k == 0) ? 8'hF0 : 8'hB4);
      wr(p, {8'h00, `FSPSL_CMD_CONFIRM});
      rs(p, 8'h00);
      wait_ready();
      rs(p, 8'h80);
    end
    // Bulk factory program: wait, pulse, done, exit
    cmd2(3'd7, `FSPSL_CMD_BULK_SETUP, {8'h00, `FSPSL_CMD_CONFIRM});
    rs(3'd7, 8'h00);
    wr(3'd7, {1'b0, 15'($urandom())});
    rs(3'd7, 8'h01);
    repeat (12) @(posedge mclk_in);
    rs(3'd7, 8'h00);
    wr(3'd7, `FSPSL_BULK_EXIT_DATA);
    wait_ready();
    rs(3'd7, 8'h80);
    // Reset in mid-run clears accumulated errors and read modes
    rst_in = 1'b1;
    repeat (2) @(posedge mclk_in);
    #1;
    rst_in = 1'b0;
    rd(3'd5, 16'hA505);
    wr(3'd5, {8'h00, `FSPSL_CMD_READ_STATUS});
    rs(3'd5, 8'h80);
    repeat (4) @(posedge mclk_in);
    finish_test();
  end
endmodule // fspsl_status_bench

// ---- test/fspsl_status_properties.sv ----
// Port assertions for the partition status block
module fspsl_status_properties #(
  parameter PW = 3
) (
  input wire mclk_in,
  input wire rst_in,
  input wire wr_in,
  input wire rd_in,
  input wire [15:0] data_out,
  input wire data_valid_out,
  input wire state_machine_ready_out,
  input wire program_busy_out,
  input wire erase_busy_out,
  input wire [PW-1:0] op_part_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  ready_busy_a: assert property (
    state_machine_ready_out == !(program_busy_out || erase_busy_out))
    else $error("Ready disagrees with busy outputs");
  one_op_a: assert property (!(program_busy_out && erase_busy_out))
    else $error("Program and erase busy together");
  read_answer_a: assert property (rd_in |=> data_valid_out)
    else $error("Read not answered next cycle");
  valid_cause_a: assert property (data_valid_out |-> $past(rd_in))
    else $error("Valid without a read");
  data_hold_a: assert property (!data_valid_out |-> $stable(data_out))
    else $error("Read data changed without a read");
  reset_state_a: assert property (disable iff (1'b0)
    rst_in |=> state_machine_ready_out && !data_valid_out &&
    data_out == 16'h0000 && op_part_out == '0)
    else $error("Reset state wrong");
  ready_fall_a: assert property (
    $fell(state_machine_ready_out) |-> $past(wr_in))
    else $error("Busy without a command");
  owner_stable_a: assert property (
    !state_machine_ready_out && $past(!state_machine_ready_out)
    |-> $stable(op_part_out))
    else $error("Owner changed during operation");
  cover property (erase_busy_out && data_valid_out);
  cover property (program_busy_out && data_valid_out);
  cover property ($rose(state_machine_ready_out));
endmodule // fspsl_status_properties

bind fspsl_status fspsl_status_properties #(.PW(PW)) i_fspsl_status_properties (
  .mclk_in(mclk_in),
  .rst_in(rst_in),
  .wr_in(wr_in),
  .rd_in(rd_in),
  .data_out(data_out),
  .data_valid_out(data_valid_out),
  .state_machine_ready_out(state_machine_ready_out),
  .program_busy_out(program_busy_out),
  .erase_busy_out(erase_busy_out),
  .op_part_out(op_part_out)
);

// ---- verilog/fspsl_busy_enc.v ----
// Joint encoding of the ready and other-partition-busy status bits
module fspsl_busy_enc #(
  parameter PW = 3
) (
  input wire op_busy_in,
  input wire bulk_mode_in,
  input wire bulk_pulse_in,
  input wire [PW-1:0] busy_part_in,
  input wire [PW-1:0] addr_part_in,
  output reg state_machine_ready_out,
  output reg other_partition_busy_out
);

  always @* begin
    state_machine_ready_out = 1'b1;
    other_partition_busy_out = 1'b0;
    if (bulk_mode_in) begin
      // Ready for data / finished = 00, pulsing or verifying = 01
      state_machine_ready_out = 1'b0;
      other_partition_busy_out = bulk_pulse_in;
    end else if (op_busy_in) begin
      state_machine_ready_out = 1'b0;
      // Addressed partition busy = 00, another partition busy = 01
      other_partition_busy_out = (busy_part_in != addr_part_in);
    end
    // Idle or exited = 10; 11 is never produced
  end

endmodule // fspsl_busy_enc

// ---- verilog/fspsl_regs.vh ----
// Command codes, status bit positions, reset values and timing counts
`ifndef FSPSL_REGS_VH
`define FSPSL_REGS_VH

// Command codes on the low data byte
`define FSPSL_CMD_READ_ARRAY 8'hFF
`define FSPSL_CMD_READ_STATUS 8'h70
`define FSPSL_CMD_CLEAR_STATUS 8'h50
`define FSPSL_CMD_PROG_SETUP 8'h40
`define FSPSL_CMD_PROG_SETUP_ALT 8'h10
`define FSPSL_CMD_ERASE_SETUP 8'h20
`define FSPSL_CMD_BULK_SETUP 8'h30
`define FSPSL_CMD_CONFIRM 8'hD0
`define FSPSL_CMD_SUSPEND 8'hB0

// Data word that ends bulk factory-program streaming
`define FSPSL_BULK_EXIT_DATA 16'hFFFF

// Bit positions in partition_status
`define FSPSL_SR_READY 7
`define FSPSL_SR_ERASE_SUSP 6
`define FSPSL_SR_ERASE_ERR 5
`define FSPSL_SR_PROG_ERR 4
`define FSPSL_SR_SUPPLY_LOCK 3
`define FSPSL_SR_PROG_SUSP 2
`define FSPSL_SR_LOCK_VIOL 1
`define FSPSL_SR_OTHER_BUSY 0

// Upper byte of a status read
`define FSPSL_STATUS_HIGH 8'h00

// Reset values
`define FSPSL_ERR_RESET 1'b0
`define FSPSL_DATA_RESET 16'h0000

// Default operation lengths in clock cycles
`define FSPSL_PROG_CYCLES 16'h0040
`define FSPSL_ERASE_CYCLES 16'h0400
`define FSPSL_BULK_CYCLES 16'h0010

`endif

// ---- verilog/fspsl_status.v ----
// Per-partition status logic and program/erase sequencer of a flash device
// Summary of operation
// - Ready bit is low while program or erase runs, high when idle.
// - Erase-suspended bit is one only while an erase is suspended.
// - Erase-error bit set on erase failure; part of command sequence error.
// - Program-error bit set on program failure; part of sequence error.
// - Supply-lockout bit set when operation blocked by low programming supply.
// - Program-suspended bit is one only while a program is suspended.
// - Lock-violation bit set when program or erase targets a locked block.
// - Other-busy bit set while another partition programs or erases.
// - Both busy bits zero: addressed partition busy, no other active.
// - Ready zero, other-busy one: another partition is busy.
// - Ready one, other-busy zero: idle; suspend bits show suspensions.
// - Both busy bits are never one together.
// - Bulk mode: 00 ready/done, 01 pulsing/verifying, 10 exited.
// - Clear-status clears only lock, supply, program and erase error bits.
// - Busy and suspend bits change only by the sequencer.
// - Clear-status returns the addressed partition to array read.
// - Reset clears the status register as well.
// - Reads of other partitions are served while a program runs.
// - Reads of other partitions are served while an erase runs.
// - One program or erase at a time; overlap is a sequence error.
// - Factory programming uses its own bulk setup command and confirm.
// - Per-partition status, read on low byte, upper byte zero.
`include "fspsl_regs.vh"
module fspsl_status #(
  parameter NP = 8,
  parameter PW = 3,
  parameter [15:0] PROG_CYCLES = `FSPSL_PROG_CYCLES,
  parameter [15:0] ERASE_CYCLES = `FSPSL_ERASE_CYCLES,
  parameter [15:0] BULK_CYCLES = `FSPSL_BULK_CYCLES
) (
  input wire mclk_in,
  input wire rst_in,
  input wire wr_in,
  input wire rd_in,
  input wire [PW-1:0] part_in,
  input wire [15:0] data_in,
  input wire [15:0] array_data_in,
  input wire block_locked_in,
  input wire supply_low_in,
  input wire op_fail_in,
  output reg [15:0] data_out,
  output reg data_valid_out,
  output wire state_machine_ready_out,
  output wire program_busy_out,
  output wire erase_busy_out,
  output wire [PW-1:0] op_part_out
);

  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_PROG_SET = 7'h02;
  localparam [6:0] ST_ERASE_SET = 7'h04;
  localparam [6:0] ST_BULK_SET = 7'h08;
  localparam [6:0] ST_RUN = 7'h10;
  localparam [6:0] ST_BULK = 7'h20;
  localparam [6:0] ST_BULK_PULSE = 7'h40;

  reg [6:0] state;
  reg [6:0] next_state;
  reg [15:0] cnt;
  reg [15:0] next_cnt;
  reg op_erase;
  reg next_op_erase;
  reg [PW-1:0] op_part;
  reg [PW-1:0] next_op_part;
  reg prog_susp;
  reg next_prog_susp;
  reg erase_susp;
  reg next_erase_susp;
  reg [NP-1:0] status_mode;
  reg [NP-1:0] next_status_mode;
  reg [NP-1:0] err_lock;
  reg [NP-1:0] err_supply;
  reg [NP-1:0] err_prog;
  reg [NP-1:0] err_erase;
  reg [NP-1:0] set_lock;
  reg [NP-1:0] set_supply;
  reg [NP-1:0] set_prog;
  reg [NP-1:0] set_erase;
  reg [NP-1:0] clr_err;

  wire [7:0] cmd;
  wire [NP-1:0] part_sel;
  wire [NP-1:0] op_sel;
  wire op_busy;
  wire bulk_mode;
  wire ready_bit;
  wire other_bit;
  wire [7:0] status_byte;

  // One-hot select of a partition index
  function [NP-1:0] part_onehot;
    input [PW-1:0] idx;
    begin
      part_onehot = {{(NP-1){1'b0}}, 1'b1} << idx;
    end
  endfunction

  // Program setup accepts both codes; factory programming has its own bulk setup code
  function is_prog_setup;
    input [7:0] c;
    begin
      is_prog_setup = (c == `FSPSL_CMD_PROG_SETUP) ||
        (c == `FSPSL_CMD_PROG_SETUP_ALT);
    end
  endfunction

  // Commands that start a program or erase sequence
  function is_op_start;
    input [7:0] c;
    begin
      is_op_start = is_prog_setup(c) ||
        (c == `FSPSL_CMD_ERASE_SETUP) ||
        (c == `FSPSL_CMD_BULK_SETUP);
    end
  endfunction

  assign cmd = data_in[7:0];
  assign part_sel = part_onehot(part_in);
  assign op_sel = part_onehot(op_part);
  assign op_busy = (state == ST_RUN);
  assign bulk_mode = (state == ST_BULK) || (state == ST_BULK_PULSE);

  fspsl_busy_enc #(
    .PW(PW)
  ) i_fspsl_busy_enc (
    .op_busy_in(op_busy),
    .bulk_mode_in(bulk_mode),
    .bulk_pulse_in(state == ST_BULK_PULSE),
    .busy_part_in(op_part),
    .addr_part_in(part_in),
    .state_machine_ready_out(ready_bit),
    .other_partition_busy_out(other_bit)
  );

  // Status of the addressed partition; suspend bits are device wide
  assign status_byte = {
    ready_bit,
    erase_susp,
    err_erase[part_in],
    err_prog[part_in],
    err_supply[part_in],
    prog_susp,
    err_lock[part_in],
    other_bit
  };

  assign state_machine_ready_out = ~(op_busy || bulk_mode);
  assign program_busy_out = (op_busy && !op_erase) || bulk_mode;
  assign erase_busy_out = op_busy && op_erase;
  assign op_part_out = op_part;

  always @* begin
    next_state = state;
    next_cnt = cnt;
    next_op_erase = op_erase;
    next_op_part = op_part;
    next_prog_susp = prog_susp;
    next_erase_susp = erase_susp;
    next_status_mode = status_mode;
    set_lock = {NP{1'b0}};
    set_supply = {NP{1'b0}};
    set_prog = {NP{1'b0}};
    set_erase = {NP{1'b0}};
    clr_err = {NP{1'b0}};
    // Read-mode commands act anywhere but in bulk streaming and program data
    if (wr_in && !bulk_mode && state != ST_PROG_SET) begin
      if (cmd == `FSPSL_CMD_READ_ARRAY) begin
        next_status_mode = status_mode & ~part_sel;
      end
      if (cmd == `FSPSL_CMD_READ_STATUS) begin
        next_status_mode = status_mode | part_sel;
      end
      if (cmd == `FSPSL_CMD_CLEAR_STATUS) begin
        clr_err = part_sel;
        next_status_mode = status_mode & ~part_sel;
      end
    end
    case (state)
      ST_IDLE: begin
        if (wr_in && is_op_start(cmd)) begin
          next_status_mode = status_mode | part_sel;
          next_op_part = (prog_susp || erase_susp) ? op_part : part_in;
          if (prog_susp || erase_susp) begin
            // A suspended operation still owns the sequencer
            set_prog = part_sel;
            set_erase = part_sel;
          end else if (is_prog_setup(cmd)) begin
            next_state = ST_PROG_SET;
          end else if (cmd == `FSPSL_CMD_ERASE_SETUP) begin
            next_state = ST_ERASE_SET;
          end else begin
            next_state = ST_BULK_SET;
          end
        end else if (wr_in && cmd == `FSPSL_CMD_CONFIRM &&
                     (prog_susp || erase_susp)) begin
          // Resume the suspended operation where it stopped
          next_prog_susp = 1'b0;
          next_erase_susp = 1'b0;
          next_state = ST_RUN;
        end
      end
      ST_PROG_SET: begin
        if (wr_in) begin
          next_op_erase = 1'b0;
          if (block_locked_in) begin
            set_lock = op_sel;
            next_state = ST_IDLE;
          end else if (supply_low_in) begin
            set_supply = op_sel;
            next_state = ST_IDLE;
          end else begin
            next_cnt = PROG_CYCLES;
            next_state = ST_RUN;
          end
        end
      end
      ST_ERASE_SET: begin
        if (wr_in) begin
          next_op_erase = 1'b1;
          if (cmd != `FSPSL_CMD_CONFIRM) begin
            set_prog = op_sel;
            set_erase = op_sel;
            next_state = ST_IDLE;
          end else if (block_locked_in) begin
            set_lock = op_sel;
            next_state = ST_IDLE;
          end else if (supply_low_in) begin
            set_supply = op_sel;
            next_state = ST_IDLE;
          end else begin
            next_cnt = ERASE_CYCLES;
            next_state = ST_RUN;
          end
        end
      end
      ST_BULK_SET: begin
        if (wr_in) begin
          next_op_erase = 1'b0;
          if (cmd != `FSPSL_CMD_CONFIRM) begin
            set_prog = op_sel;
            set_erase = op_sel;
            next_state = ST_IDLE;
          end else if (block_locked_in) begin
            set_lock = op_sel;
            set_prog = op_sel;
            next_state = ST_IDLE;
          end else if (supply_low_in) begin
            set_supply = op_sel;
            set_prog = op_sel;
            next_state = ST_IDLE;
          end else begin
            next_state = ST_BULK;
          end
        end
      end
      ST_RUN: begin
        if (wr_in && cmd == `FSPSL_CMD_SUSPEND) begin
          next_erase_susp = op_erase;
          next_prog_susp = ~op_erase;
          next_state = ST_IDLE;
        end else if (wr_in && is_op_start(cmd)) begin
          // Second program or erase while one runs is refused
          set_prog = part_sel;
          set_erase = part_sel;
        end
        if (!(wr_in && cmd == `FSPSL_CMD_SUSPEND)) begin
          if (cnt == 16'h0000) begin
            if (op_fail_in && op_erase) begin
              set_erase = set_erase | op_sel;
            end
            if (op_fail_in && !op_erase) begin
              set_prog = set_prog | op_sel;
            end
            next_state = ST_IDLE;
          end else begin
            next_cnt = cnt - 16'h0001;
          end
        end
      end
      ST_BULK: begin
        if (wr_in) begin
          if (data_in == `FSPSL_BULK_EXIT_DATA) begin
            next_state = ST_IDLE;
          end else begin
            next_cnt = BULK_CYCLES;
            next_state = ST_BULK_PULSE;
          end
        end
      end
      ST_BULK_PULSE: begin
        if (cnt == 16'h0000) begin
          if (op_fail_in) begin
            set_prog = op_sel;
          end
          next_state = ST_BULK;
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Error bits: set wins over clear, bits accumulate until cleared
  always @(posedge mclk_in) begin
    if (rst_in) begin
      err_lock <= {NP{`FSPSL_ERR_RESET}};
      err_supply <= {NP{`FSPSL_ERR_RESET}};
      err_prog <= {NP{`FSPSL_ERR_RESET}};
      err_erase <= {NP{`FSPSL_ERR_RESET}};
    end else begin
      err_lock <= (err_lock & ~clr_err) | set_lock;
      err_supply <= (err_supply & ~clr_err) | set_supply;
      err_prog <= (err_prog & ~clr_err) | set_prog;
      err_erase <= (err_erase & ~clr_err) | set_erase;
    end
  end

  // Sequencer state, suspend bits and read modes
  always @(posedge mclk_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      cnt <= 16'h0000;
      op_erase <= 1'b0;
      op_part <= {PW{1'b0}};
      prog_susp <= 1'b0;
      erase_susp <= 1'b0;
      status_mode <= {NP{1'b0}};
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      op_erase <= next_op_erase;
      op_part <= next_op_part;
      prog_susp <= next_prog_susp;
      erase_susp <= next_erase_susp;
      status_mode <= next_status_mode;
    end
  end

  // Read port: status on low byte, array data otherwise
  always @(posedge mclk_in) begin
    if (rst_in) begin
      data_out <= `FSPSL_DATA_RESET;
      data_valid_out <= 1'b0;
    end else begin
      data_valid_out <= rd_in;
      if (rd_in) begin
        if (status_mode[part_in] || bulk_mode) begin
          data_out <= {`FSPSL_STATUS_HIGH, status_byte};
        end else begin
          // Array reads of any partition proceed during program and erase runs, not in bulk mode
          data_out <= array_data_in;
        end
      end
    end
  end

endmodule // fspsl_status
